//--- rtl/i2c_master_condition_regs.vh
`ifndef I2C_MASTER_CONDITION_REGS_VH
`define I2C_MASTER_CONDITION_REGS_VH
// transfer bit numbering, first bit is 0
`define BIT_EIGHTH      4'h7
`define BIT_NINTH       4'h8
// transfer states
`define XS_IDLE         3'h0
`define XS_LOW          3'h1
`define XS_HIGH         3'h2
`define XS_WAIT8        3'h3
`define XS_WAIT9        3'h4
// condition kinds
`define CK_START        2'h0
`define CK_RESTART      2'h1
`define CK_STOP         2'h2
// last step index of each condition sequence
`define STEP_LAST_START 2'h2
`define STEP_LAST_RSTA  2'h3
`define STEP_LAST_STOP  2'h2
// reset values
`define DIV_RESET       8'h00
`define TX_RESET        9'h1ff
`endif

//--- rtl/i2c_master_condition.v
`timescale 1ns/1ps
`include "i2c_master_condition_regs.vh"
module i2c_master_condition (
   input  wire       i_clk,
   input  wire       i_arst_n,
   input  wire       i_bus_mode_select,
   input  wire [7:0] i_baud_divider,
   input  wire       i_start_request,
   input  wire       i_restart_request,
   input  wire       i_stop_request,
   input  wire       i_condition_generator_select,
   input  wire       i_condition_detected,
   input  wire       i_arbitration_update_select,
   input  wire       i_arbitration_clear,
   input  wire       i_output_stop_on_loss_enable,
   input  wire       i_eighth_bit_wait,
   input  wire       i_clock_force_low,
   input  wire       i_ninth_bit_wait,
   input  wire       i_clock_phase_delay,
   input  wire       i_clock_sync_enable,
   input  wire       i_release_on_foreign_stop,
   input  wire       i_foreign_stop_detected,
   input  wire       i_bit_order_select,
   input  wire [2:0] i_data_delay_field,
   input  wire       i_data_output_disable,
   input  wire [8:0] i_tx_data,
   input  wire       i_tx_write,
   input  wire       i_bus_clock_pin,
   input  wire       i_bus_data_pin,
   output wire       o_bus_clock_out,
   output wire       o_bus_clock_oe_n,
   output wire       o_bus_data_out,
   output wire       o_bus_data_oe_n,
   output wire       o_arbitration_lost_flag,
   output wire       o_condition_irq,
   output wire       o_tx_ready,
   output wire [2:0] o_pending_requests
);

   reg  [2:0] xs_reg;
   reg  [7:0] cnt_reg;
   reg  [3:0] bit_reg;
   reg  [8:0] tx_reg;
   reg        scl_int_reg;
   reg        byte_lost_reg;
   reg        arb_reg;
   reg        clk_q_reg;
   reg        clk_qq_reg;
   reg  [7:0] dly_reg;
   reg        start_pend_reg;
   reg        rsta_pend_reg;
   reg        stop_pend_reg;
   reg        cond_act_reg;
   reg  [1:0] cond_kind_reg;
   reg  [1:0] cond_step_reg;
   reg  [7:0] cond_cnt_reg;
   reg        cond_scl_reg;
   reg        cond_sda_reg;
   reg        irq_reg;
   reg        cond_done;

   wire       tick = (cnt_reg == 8'h00);
   wire       xfer = (xs_reg != `XS_IDLE);
   // sync only while a byte is in flight
   wire       sync_on = i_clock_sync_enable & xfer;
   // pin seen one count source cycle late, like the filter path
   wire       clk_fell = clk_qq_reg & ~clk_q_reg;
   wire [3:0] msb_idx = `BIT_EIGHTH - bit_reg;
   wire       cur_bit = (bit_reg == `BIT_NINTH) ? tx_reg[8] :
                        i_bit_order_select ? tx_reg[msb_idx] :
                        tx_reg[bit_reg];
   // a released one that reads low means another master won
   wire       mismatch = (bit_reg < `BIT_NINTH) & cur_bit &
                         ~i_bus_data_pin;
   wire       sda_low_raw = xfer & ~cur_bit & ~byte_lost_reg;
   wire       sda_low_dly = (i_data_delay_field == 3'h0) ? sda_low_raw :
                            dly_reg[i_data_delay_field];
   wire       xfer_scl_low = xfer & ~scl_int_reg;
   wire       cond_go = i_condition_generator_select & i_bus_mode_select &
                        ~cond_act_reg &
                        (start_pend_reg | rsta_pend_reg | stop_pend_reg);
   wire [1:0] go_kind = start_pend_reg ? `CK_START :
                        rsta_pend_reg ? `CK_RESTART : `CK_STOP;
   wire [1:0] last_step = (cond_kind_reg == `CK_RESTART) ? `STEP_LAST_RSTA :
                          (cond_kind_reg == `CK_STOP) ? `STEP_LAST_STOP :
                          `STEP_LAST_START;
   wire [1:0] next_step = cond_step_reg + 2'h1;

   // {scl, sda} levels of each step, a step lasting one half period
   function [1:0] pat;
      input [1:0] kind;
      input [1:0] step;
      begin
         case (kind)
            `CK_START:   pat = (step == 2'h0) ? 2'b11 :
                               (step == 2'h1) ? 2'b10 : 2'b00;
            `CK_RESTART: pat = (step == 2'h0) ? 2'b01 :
                               (step == 2'h1) ? 2'b11 :
                               (step == 2'h2) ? 2'b10 : 2'b00;
            default:     pat = (step == 2'h0) ? 2'b00 :
                               (step == 2'h1) ? 2'b10 : 2'b11;
         endcase
      end
   endfunction

   // pin selection: transfer lines or condition generator
   wire scl_drive = i_clock_force_low |
                    (i_condition_generator_select ? ~cond_scl_reg :
                     xfer_scl_low);
   wire sda_drive = ~i_data_output_disable &
                    ~(arb_reg & i_output_stop_on_loss_enable) &
                    (i_condition_generator_select ? ~cond_sda_reg :
                     sda_low_dly);

   assign o_bus_clock_out         = 1'b0;
   assign o_bus_data_out          = 1'b0;
   assign o_bus_clock_oe_n        = ~scl_drive;
   assign o_bus_data_oe_n         = ~sda_drive;
   assign o_arbitration_lost_flag = arb_reg;
   assign o_condition_irq         = irq_reg;
   assign o_tx_ready              = ~xfer;
   assign o_pending_requests      = {stop_pend_reg, rsta_pend_reg,
                                     start_pend_reg};

   always @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         clk_q_reg  <= 1'b1;
         clk_qq_reg <= 1'b1;
         dly_reg    <= 8'h00;
      end else begin
         clk_q_reg  <= i_bus_clock_pin;
         clk_qq_reg <= clk_q_reg;
         dly_reg    <= {dly_reg[6:0], sda_low_raw};
      end
   end

   // byte transfer engine
   always @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         xs_reg        <= `XS_IDLE;
         cnt_reg       <= `DIV_RESET;
         bit_reg       <= 4'h0;
         tx_reg        <= `TX_RESET;
         scl_int_reg   <= 1'b1;
         byte_lost_reg <= 1'b0;
         arb_reg       <= 1'b0;
      end else begin
         if (i_arbitration_clear)
            arb_reg <= 1'b0;
         if (xfer & i_release_on_foreign_stop &
             i_foreign_stop_detected) begin
            xs_reg      <= `XS_IDLE;
            scl_int_reg <= 1'b1;
         end else begin
            case (xs_reg)
               `XS_IDLE: begin
                  scl_int_reg <= 1'b1;
                  if (i_tx_write & i_bus_mode_select &
                      ~i_condition_generator_select) begin
                     tx_reg        <= i_tx_data;
                     bit_reg       <= 4'h0;
                     byte_lost_reg <= 1'b0;
                     cnt_reg       <= i_baud_divider;
                     scl_int_reg   <= 1'b0;
                     xs_reg        <= `XS_LOW;
                  end
               end
               `XS_LOW: begin
                  if (!tick) begin
                     cnt_reg <= cnt_reg - 8'h01;
                  end else if (i_clock_sync_enable & ~clk_q_reg) begin
                     // let go of the line, count waits for the wire
                     scl_int_reg <= 1'b1;
                     cnt_reg     <= 8'h00;
                  end else begin
                     scl_int_reg <= 1'b1;
                     cnt_reg     <= i_baud_divider;
                     xs_reg      <= `XS_HIGH;
                     if (mismatch)
                        byte_lost_reg <= 1'b1;
                     if (~i_arbitration_update_select &
                         (bit_reg < `BIT_NINTH))
                        arb_reg <= mismatch;
                  end
               end
               `XS_HIGH: begin
                  if (tick | (sync_on & clk_fell)) begin
                     scl_int_reg <= 1'b0;
                     cnt_reg     <= i_baud_divider;
                     if (bit_reg == `BIT_EIGHTH) begin
                        if (i_arbitration_update_select & byte_lost_reg)
                           arb_reg <= 1'b1;
                        if (i_eighth_bit_wait) begin
                           xs_reg <= `XS_WAIT8;
                        end else begin
                           bit_reg <= `BIT_NINTH;
                           xs_reg  <= `XS_LOW;
                        end
                     end else if (bit_reg == `BIT_NINTH) begin
                        if (i_clock_phase_delay & i_ninth_bit_wait)
                           xs_reg <= `XS_WAIT9;
                        else
                           xs_reg <= `XS_IDLE;
                     end else begin
                        bit_reg <= bit_reg + 4'h1;
                        xs_reg  <= `XS_LOW;
                     end
                  end else begin
                     cnt_reg <= cnt_reg - 8'h01;
                  end
               end
               `XS_WAIT8: begin
                  if (!i_eighth_bit_wait) begin
                     bit_reg <= `BIT_NINTH;
                     cnt_reg <= i_baud_divider;
                     xs_reg  <= `XS_LOW;
                  end
               end
               `XS_WAIT9: begin
                  if (!i_ninth_bit_wait)
                     xs_reg <= `XS_IDLE;
               end
               default: xs_reg <= `XS_IDLE;
            endcase
         end
      end
   end

   // condition generator
   always @* begin
      cond_done = cond_act_reg & (cond_cnt_reg == 8'h00) &
                  (next_step == last_step);
   end

   always @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         start_pend_reg <= 1'b0;
         rsta_pend_reg  <= 1'b0;
         stop_pend_reg  <= 1'b0;
         cond_act_reg   <= 1'b0;
         cond_kind_reg  <= `CK_START;
         cond_step_reg  <= 2'h0;
         cond_cnt_reg   <= `DIV_RESET;
         cond_scl_reg   <= 1'b1;
         cond_sda_reg   <= 1'b1;
         irq_reg        <= 1'b0;
      end else begin
         // a new request in the completion cycle stays pending
         if (cond_done & (cond_kind_reg == `CK_START))
            start_pend_reg <= 1'b0;
         if (cond_done & (cond_kind_reg == `CK_RESTART))
            rsta_pend_reg <= 1'b0;
         if (cond_done & (cond_kind_reg == `CK_STOP))
            stop_pend_reg <= 1'b0;
         if (i_start_request & i_bus_mode_select)
            start_pend_reg <= 1'b1;
         if (i_restart_request & i_bus_mode_select)
            rsta_pend_reg <= 1'b1;
         if (i_stop_request & i_bus_mode_select)
            stop_pend_reg <= 1'b1;
         irq_reg <= i_condition_generator_select ? cond_done :
                    i_condition_detected;
         if (cond_go) begin
            cond_act_reg  <= 1'b1;
            cond_kind_reg <= go_kind;
            cond_step_reg <= 2'h0;
            cond_cnt_reg  <= i_baud_divider;
            {cond_scl_reg, cond_sda_reg} <= pat(go_kind, 2'h0);
         end else if (cond_act_reg) begin
            if (cond_cnt_reg != 8'h00) begin
               cond_cnt_reg <= cond_cnt_reg - 8'h01;
            end else begin
               cond_step_reg <= next_step;
               cond_cnt_reg  <= i_baud_divider;
               {cond_scl_reg, cond_sda_reg} <=
                  pat(cond_kind_reg, next_step);
               if (next_step == last_step)
                  cond_act_reg <= 1'b0;
            end
         end
      end
   end

endmodule // i2c_master_condition

//--- sim/i2c_bus_partner.sv
`timescale 1ns/1ps
module i2c_bus_partner (
   input  wire logic i_clock_oe_n,
   input  wire logic i_data_oe_n,
   input  wire logic i_hold_data_low,
   input  wire logic i_hold_clock_low,
   output wire logic o_bus_clock,
   output wire logic o_bus_data
);
   // pull-ups: a released line reads high
   // rival master stretching the clock low, wired-and as well
   assign o_bus_clock = i_clock_oe_n & ~i_hold_clock_low;
   // rival master holding data low wins the wired-and
   assign o_bus_data  = i_data_oe_n & ~i_hold_data_low;
endmodule // i2c_bus_partner

//--- sim/i2c_master_condition_monitor.sv
`timescale 1ns/1ps
module i2c_master_condition_monitor (
   input wire       i_clk,
   input wire       i_arst_n,
   input wire       i_bus_mode_select,
   input wire [7:0] i_baud_divider,
   input wire       i_condition_generator_select,
   input wire       i_condition_detected,
   input wire       i_output_stop_on_loss_enable,
   input wire       i_eighth_bit_wait,
   input wire       i_clock_force_low,
   input wire       i_foreign_stop_detected,
   input wire       i_data_output_disable,
   input wire       i_tx_write,
   input wire       o_bus_clock_out,
   input wire       o_bus_data_out,
   input wire       o_bus_clock_oe_n,
   input wire       o_bus_data_oe_n,
   input wire       o_arbitration_lost_flag,
   input wire       o_condition_irq,
   input wire       o_tx_ready,
   input wire [2:0] o_pending_requests
);
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_arst_n);
   logic [8:0] low_cnt_reg;
   // waits, forcing and aborts stretch a phase on purpose
   logic       odd_byte_reg;
   always @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         low_cnt_reg  <= 9'h000;
         odd_byte_reg <= 1'b0;
      end else begin
         low_cnt_reg  <= (o_bus_clock_oe_n | o_tx_ready) ? 9'h000
                                                         : low_cnt_reg + 9'h001;
         odd_byte_reg <= (odd_byte_reg & ~o_tx_ready) | i_eighth_bit_wait
                         | i_clock_force_low | i_foreign_stop_detected;
      end
   end
   property p_force_low;
      i_clock_force_low [*3] |-> !o_bus_clock_oe_n;
   endproperty
   a_force_low: assert property (p_force_low) else $error("clock not forced");
   property p_data_off;
      i_data_output_disable [*3] |-> o_bus_data_oe_n;
   endproperty
   a_data_off: assert property (p_data_off) else $error("data driven");
   property p_loss;
      o_arbitration_lost_flag && i_output_stop_on_loss_enable |-> o_bus_data_oe_n;
   endproperty
   a_loss: assert property (p_loss) else $error("data driven after loss");
   property p_detect;
      i_condition_detected && !i_condition_generator_select
         && i_bus_mode_select |=> o_condition_irq;
   endproperty
   a_detect: assert property (p_detect) else $error("no detect irq");
   property p_start_done;
      $fell(o_pending_requests[0]) && i_condition_generator_select
         |-> !o_bus_clock_oe_n && !o_bus_data_oe_n && o_condition_irq;
   endproperty
   a_start_done: assert property (p_start_done) else $error("bad start");
   property p_take;
      i_tx_write && o_tx_ready && i_bus_mode_select
         && !i_condition_generator_select |=> !o_tx_ready;
   endproperty
   a_take: assert property (p_take) else $error("write not taken");
   property p_half;
      $rose(o_bus_clock_oe_n) && !o_tx_ready && !odd_byte_reg
         |-> low_cnt_reg == {1'b0, i_baud_divider} + 9'h001;
   endproperty
   a_half: assert property (p_half) else $error("bad low phase");
   property p_open_drain;
      o_bus_clock_out == 1'b0 && o_bus_data_out == 1'b0;
   endproperty
   a_open_drain: assert property (p_open_drain) else $error("pin driven high");
endmodule // i2c_master_condition_monitor

bind i2c_master_condition i2c_master_condition_monitor i_monitor (.*);

//--- sim/i2c_master_condition_tb.sv
`timescale 1ns/1ps
module i2c_master_condition_tb;
   typedef struct {
      logic msb; logic [2:0] dly; logic [8:0] data; logic [8:0] seq;
   } row_t;
   row_t rows [4] = '{'{1'b1, 3'h0, 9'h1b2, 9'h165},
                      '{1'b0, 3'h0, 9'h1b2, 9'h09b},
                      '{1'b1, 3'h7, 9'h13c, 9'h079},
                      '{1'b0, 3'h1, 9'h100, 9'h001}};
   logic clk = 1'b0, arst_n = 1'b0, mode = 1'b1, sel = 1'b0, det = 1'b0;
   logic upd = 1'b0, clr = 1'b0, los = 1'b0, w8 = 1'b0, fl = 1'b0;
   logic fstop = 1'b0, msb = 1'b1, dis = 1'b0, wr = 1'b0, pull = 1'b0;
   logic sync = 1'b0, ph = 1'b0, w9 = 1'b0, rel = 1'b1, hold = 1'b0;
   logic [2:0] req = 3'h0, dly = 3'h0;
   logic [7:0] div = 8'h09;
   logic [8:0] txd = 9'h1ff, got = 9'h000;
   int         fail_count = 0, num_checks = 0, cycles = 0, k;
   wire        scl_oe_n, sda_oe_n, flag, irq, ready, scl, sda;
   wire  [2:0] pend;
   // clock source taken as internal throughout
   i2c_master_condition i_dut (.i_clk(clk), .i_arst_n(arst_n),
      .i_bus_mode_select(mode), .i_baud_divider(div),
      .i_start_request(req[0]), .i_restart_request(req[1]),
      .i_stop_request(req[2]), .i_condition_generator_select(sel),
      .i_condition_detected(det), .i_arbitration_update_select(upd),
      .i_arbitration_clear(clr), .i_output_stop_on_loss_enable(los),
      .i_eighth_bit_wait(w8), .i_clock_force_low(fl),
      .i_ninth_bit_wait(w9), .i_clock_phase_delay(ph),
      .i_clock_sync_enable(sync), .i_release_on_foreign_stop(rel),
      .i_foreign_stop_detected(fstop), .i_bit_order_select(msb),
      .i_data_delay_field(dly), .i_data_output_disable(dis),
      .i_tx_data(txd), .i_tx_write(wr), .i_bus_clock_pin(scl),
      .i_bus_data_pin(sda), .o_bus_clock_out(), .o_bus_clock_oe_n(scl_oe_n),
      .o_bus_data_out(), .o_bus_data_oe_n(sda_oe_n),
      .o_arbitration_lost_flag(flag), .o_condition_irq(irq),
      .o_tx_ready(ready), .o_pending_requests(pend));
   i2c_bus_partner i_partner (.i_clock_oe_n(scl_oe_n), .i_data_oe_n(sda_oe_n),
      .i_hold_data_low(pull), .i_hold_clock_low(hold), .o_bus_clock(scl),
      .o_bus_data(sda));
   initial begin
      forever #5 clk = ~clk;
   end
   task automatic tally_and_finish();
      if (fail_count == 0 && num_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         fail_count++;
         tally_and_finish();
      end
   end
   task automatic chk(input string nm, input logic [8:0] e, input logic [8:0] a);
      num_checks++;
      if (a !== e) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", nm, e, a);
      end
   endtask
   task automatic send(input logic [8:0] d);
      while (ready !== 1'b1) @(negedge clk);
      @(posedge clk);
      txd <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   // bus bits sampled just after each clock rise, first bit ends up on top
   task automatic xfer(input logic [8:0] d);
      send(d);
      repeat (9) begin
         @(posedge scl);
         @(negedge clk);
         got = {got[7:0], sda};
      end
      while (ready !== 1'b1) @(negedge clk);
   endtask
   initial begin
      repeat (3) @(posedge clk);
      @(negedge clk);
      chk("reset", 9'h0c8, {1'b0, scl_oe_n, sda_oe_n, flag, irq, ready, pend});
      @(posedge clk);
      arst_n <= 1'b1;
      foreach (rows[i]) begin
         @(posedge clk);
         msb <= rows[i].msb;
         dly <= rows[i].dly;
         xfer(rows[i].data);
         chk("serial", rows[i].seq, got);
         chk("lost", 9'h000, {8'h00, flag});
      end
      @(posedge clk);
      dly <= 3'h0;
      msb <= 1'b1;
      dis <= 1'b1;
      xfer(9'h000);
      chk("disabled data", 9'h1ff, got);
      @(posedge clk);
      dis <= 1'b0;
      los <= 1'b1;
      pull <= 1'b1;
      xfer(9'h1bf);
      chk("lost", 9'h001, {8'h00, flag});
      @(posedge clk);
      pull <= 1'b0;
      xfer(9'h1ff);
      chk("lost", 9'h000, {8'h00, flag});
      @(posedge clk);
      upd <= 1'b1;
      pull <= 1'b1;
      fork
         xfer(9'h1ff);
         begin
            repeat (3) @(posedge scl);
            @(negedge clk);
            chk("lost mid byte", 9'h000, {8'h00, flag});
         end
      join
      chk("lost", 9'h001, {8'h00, flag});
      @(posedge clk);
      clr <= 1'b1;
      pull <= 1'b0;
      @(posedge clk);
      clr <= 1'b0;
      upd <= 1'b0;
      w8 <= 1'b1;
      @(negedge clk);
      chk("cleared", 9'h000, {8'h00, flag});
      fork
         xfer(9'h1b2);
         begin
            repeat (8) @(posedge scl);
            @(negedge scl);
            repeat (30) @(negedge clk);
            chk("held clock", 9'h000, {8'h00, scl_oe_n});
            @(posedge clk);
            w8 <= 1'b0;
         end
      join
      @(posedge clk);
      sync <= 1'b1;
      fork
         begin
            xfer(9'h1b2);
            chk("synced serial", 9'h165, got);
         end
         begin
            @(posedge scl);
            @(negedge scl);
            @(posedge clk);
            hold <= 1'b1;
            repeat (30) @(negedge clk);
            chk("released", 9'h001, {8'h00, scl_oe_n});
            @(posedge clk);
            hold <= 1'b0;
            repeat (8) @(negedge clk);
            chk("high kept", 9'h001, {8'h00, scl_oe_n});
            @(posedge scl);
            @(posedge clk);
            hold <= 1'b1;
            repeat (3) @(posedge clk);
            hold <= 1'b0;
            @(negedge clk);
            chk("synced fall", 9'h000, {8'h00, scl_oe_n});
         end
      join
      for (k = 0; k < 2; k++) begin
         @(posedge clk);
         sync <= 1'b0;
         ph <= k[0];
         w9 <= 1'b1;
         fork
            xfer(9'h1ff);
            begin
               repeat (9) @(posedge scl);
               repeat (40) @(negedge clk);
               chk("ninth", k ? 9'h000 : 9'h001, {8'h00, scl_oe_n});
               @(posedge clk);
               w9 <= 1'b0;
            end
         join
      end
      for (k = 0; k < 2; k++) begin
         @(posedge clk);
         fl <= !k[0];
         repeat (3) @(negedge clk);
         chk("forced clock", 9'(k), {8'h00, scl_oe_n});
      end
      for (k = 0; k < 3; k++) begin
         @(posedge clk);
         req <= 3'h1 << k;
         @(posedge clk);
         req <= 3'h0;
         @(negedge clk);
         chk("pending", 9'h001 << k, {6'h00, pend});
         @(posedge clk);
         sel <= 1'b1;
         while (irq !== 1'b1) @(negedge clk);
         chk("lines", (k == 2) ? 9'h003 : 9'h000, {7'h00, scl_oe_n, sda_oe_n});
         @(posedge clk);
         sel <= 1'b0;
      end
      mode <= 1'b0;
      req <= 3'h1;
      @(posedge clk);
      req <= 3'h0;
      mode <= 1'b1;
      det <= 1'b1;
      @(posedge clk);
      det <= 1'b0;
      @(negedge clk);
      chk("refused", 9'h000, {6'h00, pend});
      chk("detect irq", 9'h001, {8'h00, irq});
      for (k = 0; k < 2; k++) begin
         @(posedge clk);
         rel <= k[0];
         send(9'h1b2);
         repeat (2) @(posedge scl);
         @(posedge clk);
         fstop <= 1'b1;
         @(posedge clk);
         fstop <= 1'b0;
         repeat (40) @(negedge clk);
         chk("aborted", k ? 9'h003 : 9'h001, {7'h00, ready, scl_oe_n});
         while (ready !== 1'b1) @(negedge clk);
      end
      tally_and_finish();
   end
endmodule // i2c_master_condition_tb
